// ===== rtl/bridge_pkg.sv
// Package of constants for the host to peripheral bus adapter.
// Assumes a 20 MHz host clock.
package bridge_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS   = 50;
   localparam int ACCESS_MIN_NS     = 400;
   localparam int CHAIN_FIRST_NS    = 350;
   localparam int CHAIN_MIDDLE_NS   = 150;
   localparam int CHAIN_LAST_NS     = 100;
   localparam int CHAIN_TOTAL_NS    = CHAIN_FIRST_NS + CHAIN_MIDDLE_NS
                                      + CHAIN_LAST_NS;
   // Strictly longer than the least access: add one cycle
   localparam int ACCESS_CYCLES     = ACCESS_MIN_NS / CLOCK_PERIOD_NS + 1;
   localparam int CHAIN_CYCLES      =
      (CHAIN_TOTAL_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int ACK_CYCLES        = ACCESS_CYCLES + CHAIN_CYCLES;

   // ----------------------------------------------------------------
   // Counter and codes
   // ----------------------------------------------------------------
   localparam int          COUNT_W        = 5;
   localparam logic [4:0]  COUNT_RESET    = 5'h00;
   localparam logic [2:0]  FC_INT_ACK     = 3'h7;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACCESS,
      ST_ACK
   } phase_t;

endpackage

// ===== rtl/bus_adapter.sv
// Adapter between a 16-bit asynchronous host bus and 8-bit peripherals.
// Assumes host bus inputs synchronous to clock and decoding outside.
//
// Overview of operation
// - Control and data registers reach directly in one access, no address first.
// - Indirect write: control register gets address, then data, in two accesses.
// - Indirect read: write address to control register, then read it back.
// - Read and write strobes come from direction, address strobe, byte strobes.
// - Interrupt acknowledge asserts when all three function code lines are high.
// - Acknowledge cycles allow 350, 150 and 100 ns daisy chain delays.
// - State counter times the acknowledge; output driven only while asserted.
// - Peripheral clock is the host clock divided by two.
// - Peripherals capture write data at write strobe falling edge.
// - Each acknowledged peripheral access is held active longer than 400 ns.
// - Read and write strobes are never low together.
// - Acknowledge assertion is qualified by the peripheral clock being high, on a host clock edge mid peripheral cycle.
module bus_adapter
   import bridge_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic       adapter_enable_n,
   input  wire logic       address_strobe_n,
   input  wire logic       lower_byte_strobe_n,
   input  wire logic       upper_byte_strobe_n,
   input  wire logic       read_not_write,
   input  wire logic [2:0] function_code_lines,
   output logic            periph_read_n,
   output logic            periph_write_n,
   output logic            interrupt_acknowledge_n,
   output logic            periph_clock,
   output logic            transfer_acknowledge_n_o,
   output logic            transfer_acknowledge_n_oe
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Interrupt acknowledge when every function code line is high
   function automatic logic is_int_ack(
      input logic [2:0] code
   );
      is_int_ack = (code == FC_INT_ACK);
   endfunction

   // Counter value one step on, kept to the counter width
   function automatic logic [COUNT_W-1:0] count_step(
      input logic [COUNT_W-1:0] value
   );
      count_step = value + COUNT_W'(1);
   endfunction

   // Acknowledge may start once the count is reached and pclk is high
   function automatic logic ack_due(
      input logic [COUNT_W-1:0] value,
      input logic [COUNT_W-1:0] limit,
      input logic               pclk
   );
      ack_due = (count_step(value) >= limit) && pclk;
   endfunction

   // ----------------------------------------------------------------
   // Cycle decode
   // ----------------------------------------------------------------
   logic               int_ack_cycle;
   logic               active;
   logic               read_low;
   logic               write_low;
   logic [COUNT_W-1:0] target;

   assign int_ack_cycle = is_int_ack(function_code_lines);
   // One direct access per strobe; indirect sequencing stays in peripheral
   assign active = !adapter_enable_n && !address_strobe_n
                   && (!lower_byte_strobe_n || !upper_byte_strobe_n
                       || int_ack_cycle);
   // Neither strobe goes low in an acknowledge cycle
   assign read_low  = read_not_write && !int_ack_cycle;
   assign write_low = !read_not_write && !int_ack_cycle;
   assign target    = int_ack_cycle ? COUNT_W'(ACK_CYCLES)
                                    : COUNT_W'(ACCESS_CYCLES);

   // ----------------------------------------------------------------
   // Peripheral clock
   // ----------------------------------------------------------------
   logic pclk_q;
   logic pclk_d;

   always_comb begin
      pclk_d = !pclk_q;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pclk_q <= 1'b0;
      end else begin
         pclk_q <= pclk_d;
      end
   end

   // ----------------------------------------------------------------
   // State counter
   // ----------------------------------------------------------------
   phase_t             phase_q;
   phase_t             phase_d;
   logic [COUNT_W-1:0] count_q;
   logic [COUNT_W-1:0] count_d;

   always_comb begin
      phase_d = phase_q;
      count_d = count_q;
      if (!active) begin
         phase_d = ST_IDLE;
         count_d = COUNT_RESET;
      end else begin
         case (phase_q)
            ST_IDLE: begin
               phase_d = ST_ACCESS;
               count_d = COUNT_RESET;
            end
            ST_ACCESS: begin
               count_d = count_step(count_q);
               // Acknowledge starts on a host clock edge, mid pclk cycle
               if (ack_due(count_q, target, pclk_q)) begin
                  phase_d = ST_ACK;
               end
            end
            ST_ACK: begin
               phase_d = ST_ACK;
            end
            default: begin
               phase_d = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= ST_IDLE;
         count_q <= COUNT_RESET;
      end else begin
         phase_q <= phase_d;
         count_q <= count_d;
      end
   end

   // ----------------------------------------------------------------
   // Transfer acknowledge
   // ----------------------------------------------------------------
   logic ack_q;
   logic ack_d;

   always_comb begin
      ack_d = 1'b0;
      if (active) begin
         case (phase_q)
            ST_ACCESS: begin
               ack_d = ack_due(count_q, target, pclk_q);
            end
            ST_ACK: begin
               ack_d = 1'b1;
            end
            default: begin
               ack_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
      end
   end

   // ----------------------------------------------------------------
   // Peripheral strobes
   // ----------------------------------------------------------------
   logic rd_n_q;
   logic rd_n_d;
   logic wr_n_q;
   logic wr_n_d;
   logic iack_n_q;
   logic iack_n_d;

   always_comb begin
      rd_n_d   = 1'b1;
      wr_n_d   = 1'b1;
      iack_n_d = 1'b1;
      if (active) begin
         case (phase_q)
            ST_IDLE: begin
               iack_n_d = !int_ack_cycle;
               // Write strobe falls only after data has stood a cycle
               rd_n_d   = !read_low;
            end
            ST_ACCESS: begin
               iack_n_d = !int_ack_cycle;
               rd_n_d   = !read_low;
               wr_n_d   = !write_low;
            end
            ST_ACK: begin
               iack_n_d = !int_ack_cycle;
               rd_n_d   = !read_low;
               wr_n_d   = !write_low;
            end
            default: begin
               rd_n_d   = 1'b1;
               wr_n_d   = 1'b1;
               iack_n_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rd_n_q   <= 1'b1;
         wr_n_q   <= 1'b1;
         iack_n_q <= 1'b1;
      end else begin
         rd_n_q   <= rd_n_d;
         wr_n_q   <= wr_n_d;
         iack_n_q <= iack_n_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign periph_read_n             = rd_n_q;
   assign periph_write_n            = wr_n_q;
   assign interrupt_acknowledge_n   = iack_n_q;
   assign periph_clock              = pclk_q;
   assign transfer_acknowledge_n_o  = 1'b0;
   assign transfer_acknowledge_n_oe = ack_q;

endmodule

// ===== sim/bus_adapter_sva.sv
// Checker for the bus adapter, watching its ports only.
// Assumes a single clock domain and the package constants.
module bus_adapter_sva
   import bridge_pkg::*;
(
   input wire logic       clock,
   input wire logic       arst_n,
   input wire logic       adapter_enable_n,
   input wire logic       address_strobe_n,
   input wire logic       lower_byte_strobe_n,
   input wire logic       upper_byte_strobe_n,
   input wire logic       read_not_write,
   input wire logic [2:0] function_code_lines,
   input wire logic       periph_read_n,
   input wire logic       periph_write_n,
   input wire logic       interrupt_acknowledge_n,
   input wire logic       periph_clock,
   input wire logic       transfer_acknowledge_n_o,
   input wire logic       transfer_acknowledge_n_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       act;
   logic       iak;
   logic       oe;
   logic [4:0] run_q;
   logic [4:0] run_d;
   assign oe = transfer_acknowledge_n_oe;
   assign iak = function_code_lines == FC_INT_ACK;
   assign act = !adapter_enable_n && !address_strobe_n
                && (!lower_byte_strobe_n || !upper_byte_strobe_n || iak);
   always_comb run_d = act ? run_q + {4'h0, run_q != 5'h1F} : 5'h00;
   always_ff @(posedge clock or negedge arst_n)
      if (!arst_n) run_q <= 5'h00;
      else run_q <= run_d;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   strobe_excl_a: assert property (periph_read_n || periph_write_n)
      else $error("read and write strobes low together");
   pclk_div_a: assert property ($past(arst_n) |->
      periph_clock != $past(periph_clock))
      else $error("peripheral clock not halved");
   ack_wait_a: assert property ($rose(oe) && !iak |->
      run_q inside {[10:12]})
      else $error("access acknowledged at wrong time");
   iack_wait_a: assert property ($rose(oe) && iak |->
      run_q inside {[22:24]})
      else $error("interrupt acknowledge at wrong time");
   ack_hold_a: assert property (oe && act |=> oe)
      else $error("acknowledge dropped early");
   ack_clear_a: assert property (!act |=>
      !oe && periph_read_n && periph_write_n)
      else $error("access not cleared");
   iack_out_a: assert property (act && iak |=>
      !interrupt_acknowledge_n && periph_read_n && periph_write_n)
      else $error("interrupt acknowledge missing");
   wr_cause_a: assert property ($fell(periph_write_n) |->
      $past(act) && !$past(read_not_write) && !oe)
      else $error("write strobe without write");
   ack_line_a: assert property (transfer_acknowledge_n_o == 1'b0)
      else $error("acknowledge line driven high");
endmodule
bind bus_adapter bus_adapter_sva chk_u (.*);

// ===== sim/periph_model.sv
// Peripheral model: counts writes and tracks the indirect address step.
// Assumes strobes come straight from the adapter.
module periph_model (
   input  wire logic write_n,
   input  wire logic read_n,
   output logic [7:0] writes,
   output logic       step_q
);
   timeunit 1ns;
   timeprecision 1ns;
   initial writes = 8'h00;
   initial step_q = 1'b0;
   always @(negedge write_n) begin
      writes += 8'h01;
      step_q = !step_q;
   end
   always @(negedge read_n) step_q = 1'b0;
endmodule

// ===== sim/tb_bus_adapter.sv
// Bench for the bus adapter: random host accesses and an abort.
// Assumes the bound checker and the peripheral model.
module tb_bus_adapter;
   import bridge_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, arst_n = 1'b0, en_n = 1'b1, as_n = 1'b1, rnw = 1'b1;
   logic lds_n = 1'b1, uds_n = 1'b1, rd_n, wr_n, ia_n, pclk, ack_o, oe, prv;
   logic [2:0] fc = 3'h0;
   logic [7:0] writes, exp_q[$];
   int failures = 0, n_checks = 0, nw = 0, seed = 32'h6B515974;
   always #25 clock = ~clock;
   bus_adapter dut_u (.clock(clock), .arst_n(arst_n), .adapter_enable_n(en_n),
      .address_strobe_n(as_n), .lower_byte_strobe_n(lds_n),
      .upper_byte_strobe_n(uds_n), .read_not_write(rnw),
      .function_code_lines(fc), .periph_read_n(rd_n), .periph_write_n(wr_n),
      .interrupt_acknowledge_n(ia_n), .periph_clock(pclk),
      .transfer_acknowledge_n_o(ack_o), .transfer_acknowledge_n_oe(oe));
   periph_model peri_u (.write_n(wr_n), .read_n(rd_n), .writes(writes),
      .step_q());
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task access(input int kind, input logic abort);
      int i;
      @(negedge clock);
      en_n = 1'b0;
      as_n = 1'b0;
      rnw = kind != 1;
      fc = kind == 2 ? 3'h7 : 3'h5;
      // Either byte strobe reaches the peripheral's low byte lane
      {uds_n, lds_n} = kind == 2 ? 2'h3
                     : ($random(seed) % 2 ? 2'h2 : 2'h1);
      nw += kind == 1;
      if (!abort)
         exp_q.push_back(kind == 0 ? 8'h03 : kind == 1 ? 8'h05 : 8'h06);
      for (i = 0; i < 40 && !abort && oe !== 1'b1; i++) @(negedge clock);
      if (abort) repeat (4) @(negedge clock);
      if (i == 40) begin
         failures++;
         end_of_test();
      end else begin
         if (!abort) @(negedge clock);
         {en_n, as_n, uds_n, lds_n} = 4'hF;
         @(negedge clock);
      end
   endtask
   always @(negedge clock) begin
      if (oe === 1'b1 && prv !== 1'b1)
         check({5'h00, rd_n, wr_n, ia_n}, exp_q.pop_front());
      prv = oe;
   end
   initial begin
      repeat (3) @(negedge clock);
      arst_n = 1'b1;
      for (int k = 0; k < 3; k++) access(k, 1'b0);
      for (int k = 0; k < 12; k++) access($unsigned($random(seed)) % 3, 1'b0);
      access(1, 1'b1);
      access(0, 1'b0);
      check(writes, nw[7:0]);
      check({7'h00, oe}, 8'h00);
      end_of_test();
   end
endmodule
